// ===== design/mic_pkg.sv
// Purpose: Constants and types for the maskable interrupt flag controller
// Assumes: 16-bit register port, single clock domain
// Notes:   Register addresses below are full byte addresses on the peripheral bus
package mic_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 16;
	localparam int          NSRC            = 32;
	localparam int          LVL_W           = 3;
	localparam int          VEC_W           = 5;
	localparam logic [15:0] AUX_FLAGS_ADDR  = 16'h42e0;
	localparam logic [15:0] AUX_EN_ADDR     = 16'h42e2;
	localparam logic [15:0] PRI_FLAGS_ADDR  = 16'h4300;
	localparam logic [15:0] PRI_EN_ADDR     = 16'h4302;
	localparam logic [15:0] CTRL_ADDR       = 16'h4304;
	localparam logic [15:0] LVL_BASE_ADDR   = 16'h4320;
	localparam logic [15:0] IRQ_STAT_ADDR   = 16'h4340;
	localparam logic [15:0] IRQ_MASK_ADDR   = 16'h4342;
	localparam logic [15:0] PORT_MODE_ADDR  = 16'h4344;
	localparam int          LVL_REGS        = 16;
	localparam int          ENABLE_BIT      = 0;
	localparam logic [15:0] PRI_VALID       = 16'hdfff;
	localparam logic [15:0] AUX_VALID       = 16'h75fd;
	localparam logic [15:0] PORT_MASK       = 16'h00ff;
	localparam logic [15:0] ZERO16          = 16'h0000;
	localparam logic [2:0]  LVL_RESET       = 3'h0;
	localparam int          LVL_HI_LSB      = 8;
	localparam logic [4:0]  AUX_VEC_BASE    = 5'h10;
	localparam int          STAT_SET_BIT    = 0;
	localparam int          STAT_LOST_BIT   = 1;

	typedef struct packed {
		logic              valid;
		logic [LVL_W-1:0]  level;
		logic [VEC_W-1:0]  vector;
	} mic_req_type;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mic_bus_type;
endpackage : mic_pkg

// ===== design/mic_controller.sv
// Purpose: Maskable interrupt flag latching, enable, level and forwarding
// Assumes: Request lines come from logic on clock_in; plain register port
// Notes:   Flags are stored as two 16-bit registers, joined as one 32-bit vector, primary low, auxiliary high
//
// What this block does
// R1 - Controller enable bit gates flag setting only
// R2 - Enable low: flags never set on requests
// R3 - Peripheral request sets its assigned flag
// R4 - Set flag holds until cleared
// R5 - Flags readable at two status addresses
// R6 - Primary: i2c master, spi0, uart bits
// R7 - Primary: four clock timer underflows D11-D8
// R8 - Primary: port inputs on D0 to D7
// R9 - Auxiliary: remote, i2c slave, spi1 bits
// R10 - Auxiliary: 8-bit timers, shared D6 D5
// R11 - Auxiliary: rtc, adc, multi-function timer bits
// R12 - Set enabled flag forwards request, level, vector
// R13 - Write one clears flag, except level ports
// R14 - Handler software clears serviced flag
// R15 - Level port flags follow source deassertion
// R16 - Flag setting ignores per-source enables
// R17 - Per-source enable, reset disabled
// R18 - Per-source programmable level zero to seven
// R19 - Highest level wins, lowest index tie
`timescale 1ns/1ps
module mic_controller (
	// Clock and reset
	input  wire logic                       clock_in,
	input  wire logic                       rst_in,
	// Register port
	input  wire mic_pkg::mic_bus_type       bus_in,
	output logic [mic_pkg::DATA_W-1:0]      rdata_out,
	// Peripheral requests
	input  wire logic [15:0]                pri_req_in,
	input  wire logic [15:0]                aux_req_in,
	// Core side
	output mic_pkg::mic_req_type            core_req_out,
	output logic                            irq_out
);
	typedef struct packed {
		logic [15:0]                 pri_flags;
		logic [15:0]                 aux_flags;
		logic [15:0]                 pri_en;
		logic [15:0]                 aux_en;
		logic [15:0]                 ctrl;
		logic [15:0]                 port_level;
		logic [mic_pkg::NSRC*3-1:0]  levels;
		logic [1:0]                  stat;
		logic [1:0]                  mask;
		logic [15:0]                 rdata;
		mic_pkg::mic_req_type        req;
	} mic_state_type;

	mic_state_type st;
	mic_state_type next_st;

	function automatic logic [2:0] lvl_of(input logic [mic_pkg::NSRC*3-1:0] l, input int i);
		lvl_of = l[i*3 +: 3];
	endfunction : lvl_of

	function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
		hit = (a == b);
	endfunction : hit

	logic [31:0] flags_all;
	logic [31:0] en_all;
	logic [31:0] pend;
	logic        enable;
	logic [15:0] pri_set;
	logic [15:0] aux_set;
	logic [15:0] pri_clr;
	logic [15:0] aux_clr;
	logic [15:0] pri_lvl_drop;
	mic_pkg::mic_req_type best;
	logic [3:0]  lidx;

	assign enable    = st.ctrl[mic_pkg::ENABLE_BIT]; // R1
	assign flags_all = {st.aux_flags, st.pri_flags};
	assign en_all    = {st.aux_en, st.pri_en};
	assign pend      = flags_all & en_all; // R12 R17
	assign lidx      = bus_in.addr[4:1];

	always_comb begin
		best = '0;
		for (int i = 0; i < mic_pkg::NSRC; i++) begin
			if (pend[i] && (!best.valid || lvl_of(st.levels, i) > best.level)) begin // R19
				best.valid  = 1'b1;
				best.level  = lvl_of(st.levels, i); // R18
				best.vector = i[4:0];
			end
		end
	end

	always_comb begin
		// Sets only when enabled; independent of per-source enables
		pri_set = enable ? (pri_req_in & mic_pkg::PRI_VALID) : mic_pkg::ZERO16; // R2 R3 R16 R6 R7 R8
		aux_set = enable ? (aux_req_in & mic_pkg::AUX_VALID) : mic_pkg::ZERO16; // R2 R3 R16 R9 R10 R11
		pri_clr = mic_pkg::ZERO16;
		aux_clr = mic_pkg::ZERO16;
		if (bus_in.wr && hit(bus_in.addr, mic_pkg::PRI_FLAGS_ADDR)) begin
			pri_clr = bus_in.wdata & ~(st.port_level & mic_pkg::PORT_MASK); // R13 R15
		end
		if (bus_in.wr && hit(bus_in.addr, mic_pkg::AUX_FLAGS_ADDR)) begin
			aux_clr = bus_in.wdata; // R13
		end
		// Level port flags drop when the source negates
		pri_lvl_drop = st.port_level & mic_pkg::PORT_MASK & ~pri_req_in; // R15
	end

	always_comb begin
		next_st = st;
		// Set wins over clear
		next_st.pri_flags = ((st.pri_flags & ~pri_clr & ~pri_lvl_drop) | pri_set)
			& mic_pkg::PRI_VALID; // R4 R13
		next_st.aux_flags = ((st.aux_flags & ~aux_clr) | aux_set) & mic_pkg::AUX_VALID; // R4
		next_st.stat = st.stat;
		if (bus_in.wr && hit(bus_in.addr, mic_pkg::IRQ_STAT_ADDR)) begin
			next_st.stat = st.stat & ~bus_in.wdata[1:0];
		end
		if (best.valid && !st.req.valid) begin
			next_st.stat[mic_pkg::STAT_SET_BIT] = 1'b1;
		end
		if (!enable && ((pri_req_in & mic_pkg::PRI_VALID) != mic_pkg::ZERO16)) begin
			next_st.stat[mic_pkg::STAT_LOST_BIT] = 1'b1;
		end
		if (bus_in.wr) begin
			unique case (1'b1)
				hit(bus_in.addr, mic_pkg::PRI_EN_ADDR):   next_st.pri_en = bus_in.wdata; // R17
				hit(bus_in.addr, mic_pkg::AUX_EN_ADDR):   next_st.aux_en = bus_in.wdata;
				hit(bus_in.addr, mic_pkg::CTRL_ADDR):     next_st.ctrl = bus_in.wdata
					& 16'h0001; // R1
				hit(bus_in.addr, mic_pkg::IRQ_MASK_ADDR): next_st.mask = bus_in.wdata[1:0];
				hit(bus_in.addr, mic_pkg::PORT_MODE_ADDR): next_st.port_level = bus_in.wdata
					& mic_pkg::PORT_MASK;
				default: begin
					if (bus_in.addr[15:5] == mic_pkg::LVL_BASE_ADDR[15:5]) begin
						next_st.levels[{lidx, 1'b0} * 3 +: 3] = bus_in.wdata[2:0]; // R18
						next_st.levels[{lidx, 1'b1} * 3 +: 3] =
							bus_in.wdata[mic_pkg::LVL_HI_LSB +: 3];
					end
				end
			endcase
		end
		next_st.rdata = mic_pkg::ZERO16;
		if (bus_in.rd) begin
			unique case (1'b1)
				hit(bus_in.addr, mic_pkg::PRI_FLAGS_ADDR): next_st.rdata = st.pri_flags; // R5
				hit(bus_in.addr, mic_pkg::AUX_FLAGS_ADDR): next_st.rdata = st.aux_flags; // R5
				hit(bus_in.addr, mic_pkg::PRI_EN_ADDR):    next_st.rdata = st.pri_en;
				hit(bus_in.addr, mic_pkg::AUX_EN_ADDR):    next_st.rdata = st.aux_en;
				hit(bus_in.addr, mic_pkg::CTRL_ADDR):      next_st.rdata = st.ctrl;
				hit(bus_in.addr, mic_pkg::IRQ_STAT_ADDR):  next_st.rdata = {14'h0000, st.stat};
				hit(bus_in.addr, mic_pkg::IRQ_MASK_ADDR):  next_st.rdata = {14'h0000, st.mask};
				hit(bus_in.addr, mic_pkg::PORT_MODE_ADDR): next_st.rdata = st.port_level;
				default: begin
					if (bus_in.addr[15:5] == mic_pkg::LVL_BASE_ADDR[15:5]) begin
						next_st.rdata = {5'h00, st.levels[{lidx, 1'b1} * 3 +: 3],
							5'h00, st.levels[{lidx, 1'b0} * 3 +: 3]};
					end
				end
			endcase
		end
		next_st.req = best; // R12
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_out    = st.rdata;
	assign core_req_out = st.req;
	assign irq_out      = |(st.stat & st.mask);

	set_disabled_a: assert property (@(posedge clock_in) disable iff (rst_in)
		!enable |=> (st.pri_flags & ~$past(st.pri_flags)) == 16'h0000) // R2
		else $error("flag set while controller disabled");
	flag_set_a: assert property (@(posedge clock_in) disable iff (rst_in)
		enable && pri_req_in[15] |=> st.pri_flags[15]) // R3
		else $error("request did not set flag");
	flag_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
		st.aux_flags[4] && !(bus_in.wr && bus_in.addr == mic_pkg::AUX_FLAGS_ADDR)
		|=> st.aux_flags[4]) // R4
		else $error("flag dropped without clear");
	w1c_clear_a: assert property (@(posedge clock_in) disable iff (rst_in)
		bus_in.wr && bus_in.addr == mic_pkg::AUX_FLAGS_ADDR && bus_in.wdata[3]
		&& !(enable && aux_req_in[3]) |=> !st.aux_flags[3]) // R13
		else $error("write one did not clear flag");
	level_keep_a: assert property (@(posedge clock_in) disable iff (rst_in)
		st.port_level[0] && pri_req_in[0] && enable |=> st.pri_flags[0]) // R15
		else $error("level port flag cleared while asserted");
	fwd_req_a: assert property (@(posedge clock_in) disable iff (rst_in)
		pend != 32'h0 |=> core_req_out.valid) // R12
		else $error("pending flag not forwarded");
	fwd_none_a: assert property (@(posedge clock_in) disable iff (rst_in)
		pend == 32'h0 |=> !core_req_out.valid) // R17
		else $error("request without enabled flag");
	read_flags_a: assert property (@(posedge clock_in) disable iff (rst_in)
		bus_in.rd && bus_in.addr == mic_pkg::PRI_FLAGS_ADDR |=> rdata_out == $past(st.pri_flags)) // R5
		else $error("flag read mismatch");
	best_level_a: assert property (@(posedge clock_in) disable iff (rst_in)
		core_req_out.valid |-> core_req_out.level == lvl_of(st.levels, core_req_out.vector)
		|| $changed(st.levels)) // R19
		else $error("forwarded level mismatch");

	aux_off_a: assert property (@(posedge clock_in) disable iff (rst_in) // R2
		!enable |=> (st.aux_flags & ~$past(st.aux_flags)) == 16'h0000)
		else $error("aux flag set while controller disabled");

	pri_reserved_a: assert property (@(posedge clock_in) disable iff (rst_in) // R6
		!st.pri_flags[13])
		else $error("reserved primary bit set");

	aux_reserved_a: assert property (@(posedge clock_in) disable iff (rst_in) // R9
		(st.aux_flags & ~mic_pkg::AUX_VALID) == 16'h0000)
		else $error("reserved aux bit set");

	spi0_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R6
		enable && pri_req_in[14] |=> st.pri_flags[14])
		else $error("spi0 request not latched");

	uart_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R6
		enable && pri_req_in[12] |=> st.pri_flags[12])
		else $error("uart request not latched");

	timer_hi_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R7
		enable && pri_req_in[11] |=> st.pri_flags[11])
		else $error("clock timer request not latched");

	timer_lo_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R7
		enable && pri_req_in[8] |=> st.pri_flags[8])
		else $error("clock timer request not latched");

	port_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R8
		enable && pri_req_in[7] |=> st.pri_flags[7])
		else $error("port request not latched");

	remote_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R9
		enable && aux_req_in[14] |=> st.aux_flags[14])
		else $error("remote request not latched");

	slave_bus_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R9
		enable && aux_req_in[13] |=> st.aux_flags[13])
		else $error("slave bus request not latched");

	slave_xfer_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R9
		enable && aux_req_in[12] |=> st.aux_flags[12])
		else $error("slave transfer request not latched");

	spi1_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R9
		enable && aux_req_in[10] |=> st.aux_flags[10])
		else $error("spi1 request not latched");

	timer3_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R10
		enable && aux_req_in[8] |=> st.aux_flags[8])
		else $error("timer3 request not latched");

	timer2_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R10
		enable && aux_req_in[7] |=> st.aux_flags[7])
		else $error("timer2 request not latched");

	shared1_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R10
		enable && aux_req_in[6] |=> st.aux_flags[6])
		else $error("shared timer1 request not latched");

	shared0_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R10
		enable && aux_req_in[5] |=> st.aux_flags[5])
		else $error("shared timer0 request not latched");

	rtc_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R11
		enable && aux_req_in[4] |=> st.aux_flags[4])
		else $error("rtc request not latched");

	adc_end_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R11
		enable && aux_req_in[3] |=> st.aux_flags[3])
		else $error("adc end request not latched");

	adc_range_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R11
		enable && aux_req_in[2] |=> st.aux_flags[2])
		else $error("adc range request not latched");

	mft_map_a: assert property (@(posedge clock_in) disable iff (rst_in) // R11
		enable && aux_req_in[0] |=> st.aux_flags[0])
		else $error("multi-function timer request not latched");

	pri_w1c_a: assert property (@(posedge clock_in) disable iff (rst_in) // R13
		bus_in.wr && bus_in.addr == mic_pkg::PRI_FLAGS_ADDR && bus_in.wdata[15]
		&& !(enable && pri_req_in[15]) |=> !st.pri_flags[15])
		else $error("primary write one did not clear flag");

	level_w1c_keep_a: assert property (@(posedge clock_in) disable iff (rst_in) // R15
		bus_in.wr && bus_in.addr == mic_pkg::PRI_FLAGS_ADDR && st.port_level[0]
		&& st.pri_flags[0] && pri_req_in[0] |=> st.pri_flags[0])
		else $error("level port flag cleared by write");

	level_drop_a: assert property (@(posedge clock_in) disable iff (rst_in) // R15
		st.port_level[0] && !pri_req_in[0] |=> !st.pri_flags[0])
		else $error("level port flag kept after negation");

	edge_keep_a: assert property (@(posedge clock_in) disable iff (rst_in) // R4
		!st.port_level[3] && st.pri_flags[3]
		&& !(bus_in.wr && bus_in.addr == mic_pkg::PRI_FLAGS_ADDR) |=> st.pri_flags[3])
		else $error("edge port flag dropped without clear");

	pri_hold_a: assert property (@(posedge clock_in) disable iff (rst_in) // R4
		st.pri_flags[12] && !(bus_in.wr && bus_in.addr == mic_pkg::PRI_FLAGS_ADDR)
		|=> st.pri_flags[12])
		else $error("primary flag dropped without clear");

	aux_hold_a: assert property (@(posedge clock_in) disable iff (rst_in) // R4
		st.aux_flags[10] && !(bus_in.wr && bus_in.addr == mic_pkg::AUX_FLAGS_ADDR)
		|=> st.aux_flags[10])
		else $error("aux flag dropped without clear");

	set_no_enable_a: assert property (@(posedge clock_in) disable iff (rst_in) // R16
		enable && !st.pri_en[9] && pri_req_in[9] |=> st.pri_flags[9])
		else $error("flag set depends on source enable");

	en_reset_a: assert property (@(posedge clock_in) disable iff (rst_in) // R17
		$past(rst_in) |-> st.pri_en == 16'h0000 && st.aux_en == 16'h0000)
		else $error("source enables not cleared by reset");

	ctrl_reset_a: assert property (@(posedge clock_in) disable iff (rst_in) // R1
		$past(rst_in) |-> !enable)
		else $error("controller enabled after reset");

	ctrl_write_a: assert property (@(posedge clock_in) disable iff (rst_in) // R1
		bus_in.wr && bus_in.addr == mic_pkg::CTRL_ADDR |=> enable == $past(bus_in.wdata[0]))
		else $error("enable bit write lost");

	level_write_a: assert property (@(posedge clock_in) disable iff (rst_in) // R18
		bus_in.wr && bus_in.addr == mic_pkg::LVL_BASE_ADDR
		|=> lvl_of(st.levels, 0) == $past(bus_in.wdata[2:0]))
		else $error("lower level slot write lost");

	level_upper_a: assert property (@(posedge clock_in) disable iff (rst_in) // R18
		bus_in.wr && bus_in.addr == mic_pkg::LVL_BASE_ADDR
		|=> lvl_of(st.levels, 1) == $past(bus_in.wdata[10:8]))
		else $error("upper level slot write lost");

	prio_pick_a: assert property (@(posedge clock_in) disable iff (rst_in) // R19
		$past(pend[0] && pend[15]) && lvl_of(st.levels, 15) > lvl_of(st.levels, 0)
		&& $stable(st.levels) |-> core_req_out.vector != 5'h00)
		else $error("lower level source forwarded");

	vec_pending_a: assert property (@(posedge clock_in) disable iff (rst_in) // R12
		core_req_out.valid |-> (($past(pend) >> core_req_out.vector) & 32'h1) != 32'h0)
		else $error("forwarded vector not pending");

	req_idle_a: assert property (@(posedge clock_in) disable iff (rst_in) // R12
		!core_req_out.valid |-> core_req_out.level == 3'h0 && core_req_out.vector == 5'h00)
		else $error("idle request carries data");

	stat_new_a: assert property (@(posedge clock_in) disable iff (rst_in) // R12
		best.valid && !st.req.valid |=> st.stat[mic_pkg::STAT_SET_BIT])
		else $error("new request not recorded");

	lost_flag_a: assert property (@(posedge clock_in) disable iff (rst_in) // R2
		!enable && pri_req_in[15] |=> st.stat[mic_pkg::STAT_LOST_BIT])
		else $error("lost request not recorded");

	stat_clear_a: assert property (@(posedge clock_in) disable iff (rst_in) // R2
		bus_in.wr && bus_in.addr == mic_pkg::IRQ_STAT_ADDR && bus_in.wdata[1] && enable
		|=> !st.stat[mic_pkg::STAT_LOST_BIT])
		else $error("lost status not cleared");

	rdata_idle_a: assert property (@(posedge clock_in) disable iff (rst_in) // R5
		!$past(bus_in.rd) |-> rdata_out == 16'h0000)
		else $error("read data outside read slot");

	read_aux_a: assert property (@(posedge clock_in) disable iff (rst_in) // R5
		bus_in.rd && bus_in.addr == mic_pkg::AUX_FLAGS_ADDR
		|=> rdata_out == $past(st.aux_flags))
		else $error("aux flag read mismatch");

	unmapped_read_a: assert property (@(posedge clock_in) disable iff (rst_in) // R5
		bus_in.rd && bus_in.addr == 16'h4000 |=> rdata_out == 16'h0000)
		else $error("unmapped read not zero");

	mask_write_a: assert property (@(posedge clock_in) disable iff (rst_in) // R12
		bus_in.wr && bus_in.addr == mic_pkg::IRQ_MASK_ADDR
		|=> st.mask == $past(bus_in.wdata[1:0]))
		else $error("mask write lost");

	en_write_a: assert property (@(posedge clock_in) disable iff (rst_in) // R17
		bus_in.wr && bus_in.addr == mic_pkg::PRI_EN_ADDR |=> st.pri_en == $past(bus_in.wdata))
		else $error("source enable write lost");
endmodule : mic_controller

// ===== test/mic_core_model.sv
// Purpose: Core side stand-in taking forwarded requests
// Assumes: Request held while pending
// Notes:   Records last level and vector seen
`timescale 1ns/1ps
module mic_core_model (
	// Clock and reset
	input  wire logic                 clock_in,
	input  wire logic                 rst_in,
	// Request from controller
	input  wire mic_pkg::mic_req_type req_in,
	// Taken request
	output mic_pkg::mic_req_type      taken_out
);
	always_ff @(posedge clock_in) begin
		if (rst_in)
			taken_out <= '0;
		else if (req_in.valid)
			taken_out <= req_in;
	end
endmodule : mic_core_model

// ===== test/tb_maskable_irq_flag_control.sv
// Purpose: Register and request checks of the flag controller
// Assumes: Bus strobes one cycle, read data next cycle
// Notes:   Requests pulse one cycle unless level mode
`timescale 1ns/1ps
module tb_maskable_irq_flag_control;
	logic                 clock_in;
	logic                 rst_in;
	mic_pkg::mic_bus_type bus_in;
	logic [15:0]          rdata_out;
	logic [15:0]          pri_req_in;
	logic [15:0]          aux_req_in;
	mic_pkg::mic_req_type core_req_out;
	mic_pkg::mic_req_type taken;
	logic                 irq_out;
	int                   miscompares;
	int                   tests_run;

	mic_controller i_dut (.clock_in(clock_in), .rst_in(rst_in), .bus_in(bus_in),
		.rdata_out(rdata_out), .pri_req_in(pri_req_in), .aux_req_in(aux_req_in),
		.core_req_out(core_req_out), .irq_out(irq_out));
	mic_core_model i_core (.clock_in(clock_in), .rst_in(rst_in), .req_in(core_req_out),
		.taken_out(taken));

	initial begin
		clock_in = 1'b0;
		forever #12.5 clock_in = ~clock_in;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock_in);
		bus_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock_in);
		bus_in.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clock_in);
		bus_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clock_in);
		bus_in.rd <= 1'b0;
		#1 chk(rdata_out, exp);
	endtask : rd

	task automatic pulse(input logic [15:0] p, input logic [15:0] a);
		@(posedge clock_in);
		pri_req_in <= p;
		aux_req_in <= a;
		@(posedge clock_in);
		pri_req_in <= 16'h0000;
		aux_req_in <= 16'h0000;
	endtask : pulse

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report

	initial begin
		#100000;
		miscompares++;
		final_report();
	end

	initial begin
		rst_in = 1'b1;
		bus_in = '0;
		pri_req_in = 16'h0000;
		aux_req_in = 16'h0000;
		miscompares = 0;
		tests_run = 0;
		repeat (6) @(posedge clock_in);
		rst_in <= 1'b0;
		rd(mic_pkg::CTRL_ADDR, 16'h0000);
		rd(mic_pkg::PRI_EN_ADDR, 16'h0000);
		pulse(16'hdfff, 16'h75fd);
		rd(mic_pkg::PRI_FLAGS_ADDR, 16'h0000);
		rd(mic_pkg::AUX_FLAGS_ADDR, 16'h0000);
		rd(mic_pkg::IRQ_STAT_ADDR, 16'h0002);
		wr(mic_pkg::CTRL_ADDR, 16'h0001);
		rd(mic_pkg::CTRL_ADDR, 16'h0001);
		pulse(16'hdfff, 16'h75fd);
		repeat (3) @(posedge clock_in);
		#1 chk({15'h0000, core_req_out.valid}, 16'h0000);
		rd(mic_pkg::PRI_FLAGS_ADDR, mic_pkg::PRI_VALID);
		rd(mic_pkg::AUX_FLAGS_ADDR, mic_pkg::AUX_VALID);
		wr(mic_pkg::PRI_FLAGS_ADDR, 16'hffff);
		wr(mic_pkg::AUX_FLAGS_ADDR, 16'hffff);
		rd(mic_pkg::PRI_FLAGS_ADDR, 16'h0000);
		rd(mic_pkg::AUX_FLAGS_ADDR, 16'h0000);
		rd(16'h4000, 16'h0000);
		// Level 5 on source 15 beats level 0 on source 0
		wr(mic_pkg::LVL_BASE_ADDR + 16'h000e, 16'h0500);
		wr(mic_pkg::PRI_EN_ADDR, 16'h8001);
		wr(mic_pkg::IRQ_MASK_ADDR, 16'h0001);
		pulse(16'h8001, 16'h0000);
		repeat (3) @(posedge clock_in);
		#1 chk({7'h00, taken}, 16'h01af);
		chk({15'h0000, irq_out}, 16'h0001);
		wr(mic_pkg::PRI_FLAGS_ADDR, 16'h8001);
		wr(mic_pkg::IRQ_STAT_ADDR, 16'h0003);
		repeat (2) @(posedge clock_in);
		#1 chk({15'h0000, core_req_out.valid}, 16'h0000);
		chk({15'h0000, irq_out}, 16'h0000);
		// Port 0 in level mode
		wr(mic_pkg::PORT_MODE_ADDR, 16'h0001);
		@(posedge clock_in);
		pri_req_in <= 16'h0001;
		repeat (2) @(posedge clock_in);
		wr(mic_pkg::PRI_FLAGS_ADDR, 16'h0001);
		rd(mic_pkg::PRI_FLAGS_ADDR, 16'h0001);
		@(posedge clock_in);
		pri_req_in <= 16'h0000;
		repeat (2) @(posedge clock_in);
		rd(mic_pkg::PRI_FLAGS_ADDR, 16'h0000);
		final_report();
	end
endmodule : tb_maskable_irq_flag_control
